// ### include/servo_failsafe_pkg.sv
// servo_failsafe_pkg: constants and types for the servo fail-safe output stage.
// assumes one 100 MHz core clock; all widths in microseconds.
// Operation
// - frame period is 10 ms or 20 ms, one setting for all outputs.
// - each output follows a selectable source channel 1..16; outputs may share sources.
// - each output has a hold, fail-safe or off policy; reset gives hold.
// - fail-safe policy drives stored position after the delay, while interference lasts.
// - hold policy keeps emitting the last valid width during interference.
// - off policy switches the signal line off during interference.
// - written fail-safe width is 1000..2000 us in 10 us steps, reset 1500 us.
// - one global delay of 0.25, 0.50, 0.75 or 1.00 s, reset 0.75 s.
// - before the first valid frame every output drives its fail-safe width.
// - capture-all stores every current width as fail-safe, then flag returns idle.
// - while capture is pending the readout shows the live width of the selection.
// - shared outputs use the source channel's policy and fail-safe position.
// - 1500 us is the neutral centre width.
package servo_failsafe_pkg;
   localparam int NUM_OUT = 16;
   localparam int SRC_W   = 4;
   localparam int WID_W   = 11;
   localparam int STEP_W  = 7;

   localparam int CLK_PERIOD_NS = 10;
   localparam int US_NS         = 1000;
   localparam int US_CYCLES     = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int US_PER_MS     = 1000;

   localparam int FRAME_SHORT_MS = 10;
   localparam int FRAME_LONG_MS  = 20;
   localparam int DELAY_STEP_MS  = 250;

   localparam logic [1:0]        DELAY_RST_SEL = 2'h2;
   localparam logic              PERIOD_RST    = 1'h0;
   localparam logic [WID_W-1:0]  CENTER_US     = 11'h5dc;
   localparam logic [WID_W-1:0]  FS_RST_US     = 11'h5dc;
   localparam logic [WID_W-1:0]  FS_MIN_US     = 11'h3e8;
   localparam logic [WID_W-1:0]  FS_MAX_US     = 11'h7d0;
   localparam logic [WID_W-1:0]  FS_STEP_US    = 11'h00a;
   localparam logic [STEP_W-1:0] FS_MAX_STEPS  = 7'h64;

   localparam logic [1:0] POL_HOLD = 2'h0;
   localparam logic [1:0] POL_FS   = 2'h1;
   localparam logic [1:0] POL_OFF  = 2'h2;

   typedef enum logic [1:0] {
      CAP_IDLE = 2'b01,
      CAP_SAVE = 2'b10
   } cap_state_e;
endpackage : servo_failsafe_pkg

// ### design/servo_failsafe_output.sv
// servo_failsafe_output: channel mapping, servo pulse frames and fail-safe policy.
// assumes decoded channel widths arrive with a one-cycle frame_valid_in pulse.
`timescale 1ns/1ns
`default_nettype none
module servo_failsafe_output
   import servo_failsafe_pkg::*;
#(
   parameter int FRAME_SHORT_US = FRAME_SHORT_MS * US_PER_MS,
   parameter int FRAME_LONG_US  = FRAME_LONG_MS * US_PER_MS,
   parameter int DELAY_STEP_US  = DELAY_STEP_MS * US_PER_MS
)
(
   // clock and reset
   input  wire logic                            core_clk_in,
   input  wire logic                            rst_in,
   // received control frame
   input  wire logic                            frame_valid_in,
   input  wire logic [NUM_OUT-1:0][WID_W-1:0]   ch_width_in,
   // global settings
   input  wire logic                            glob_wr_in,
   input  wire logic                            period_short_in,
   input  wire logic [1:0]                      delay_sel_in,
   // per-output settings
   input  wire logic                            cfg_wr_in,
   input  wire logic [SRC_W-1:0]                servo_output_select_in,
   input  wire logic [SRC_W-1:0]                source_channel_select_in,
   input  wire logic [1:0]                      policy_in,
   input  wire logic [STEP_W-1:0]               fs_step_in,
   // capture-all and readout
   input  wire logic                            capture_arm_in,
   input  wire logic                            capture_commit_in,
   output logic                                 capture_pending_out,
   output logic [WID_W-1:0]                     position_out,
   output logic                                 interference_out,
   // servo sockets
   output logic [NUM_OUT-1:0]                   servo_out
);

   localparam int PRE_W = $clog2(US_CYCLES);
   localparam int FRM_W = 16;
   localparam int DLY_W = 22;

   typedef struct packed {
      logic [PRE_W-1:0]                  pre;
      logic [FRM_W-1:0]                  frame_us;
      logic [FRM_W-1:0]                  lost_us;
      logic [DLY_W-1:0]                  dly_us;
      logic                              seen;
      logic                              interf;
      logic                              period_short;
      logic [1:0]                        delay_sel;
      logic [NUM_OUT-1:0][1:0]           pol;
      logic [NUM_OUT-1:0][SRC_W-1:0]     src;
      logic [NUM_OUT-1:0][WID_W-1:0]     fs;
      logic [NUM_OUT-1:0][WID_W-1:0]     hold;
      cap_state_e                        cap;
      logic [WID_W-1:0]                  pos;
      logic [NUM_OUT-1:0]                servo;
   } state_s;

   state_s q;
   state_s d;

   logic                              tick;
   logic [FRM_W-1:0]                  period_us;
   logic [DLY_W-1:0]                  delay_us;
   logic                              fs_elapsed;
   logic [NUM_OUT-1:0][WID_W-1:0]     live;
   logic [NUM_OUT-1:0]                drive_en;

   assign tick       = (q.pre == PRE_W'(US_CYCLES - 1));
   assign period_us  = q.period_short ? FRM_W'(FRAME_SHORT_US) : FRM_W'(FRAME_LONG_US);
   assign delay_us   = DLY_W'((32'(q.delay_sel) + 32'd1) * 32'(DELAY_STEP_US));
   assign fs_elapsed = (q.dly_us >= delay_us);

   // policy and position come from the source channel's own slot
   for (genvar k = 0; k < NUM_OUT; k++) begin : g_live
      always_comb
      begin
         live[k]     = q.hold[k];
         drive_en[k] = 1'b1;
         if (!q.seen)
         begin
            live[k] = q.fs[q.src[k]];
         end
         else if (q.interf)
         begin
            if (q.pol[q.src[k]] == POL_FS && fs_elapsed)
            begin
               live[k] = q.fs[q.src[k]];
            end
            else if (q.pol[q.src[k]] == POL_OFF)
            begin
               drive_en[k] = 1'b0;
            end
         end
      end
   end

   always_comb
   begin
      d = q;
      d.pre = tick ? '0 : q.pre + PRE_W'(1);
      if (tick)
      begin
         // a switch to the short period mid-frame simply ends the frame early
         d.frame_us = (q.frame_us >= period_us - FRM_W'(1)) ? '0 : q.frame_us + FRM_W'(1);
         if (q.lost_us < period_us)
         begin
            d.lost_us = q.lost_us + FRM_W'(1);
         end
         if (q.interf && !fs_elapsed)
         begin
            d.dly_us = q.dly_us + DLY_W'(1);
         end
      end
      if (q.lost_us >= period_us)
      begin
         d.interf = 1'b1;
      end
      if (frame_valid_in)
      begin
         d.seen    = 1'b1;
         d.interf  = 1'b0;
         d.lost_us = '0;
         d.dly_us  = '0;
         for (int k = 0; k < NUM_OUT; k++)
         begin
            d.hold[k] = ch_width_in[q.src[k]];
         end
      end
      if (glob_wr_in)
      begin
         d.period_short = period_short_in;
         d.delay_sel    = delay_sel_in;
      end
      if (cfg_wr_in)
      begin
         d.src[servo_output_select_in] = source_channel_select_in;
         d.pol[servo_output_select_in] = (policy_in == 2'h3) ? POL_HOLD : policy_in;
         d.fs[servo_output_select_in]  = FS_MIN_US + WID_W'(
            (fs_step_in > FS_MAX_STEPS ? FS_MAX_STEPS : fs_step_in) * FS_STEP_US);
      end
      unique case (q.cap)
         CAP_IDLE:
         begin
            if (capture_arm_in)
            begin
               d.cap = CAP_SAVE;
            end
         end
         CAP_SAVE:
         begin
            if (capture_commit_in)
            begin
               for (int k = 0; k < NUM_OUT; k++)
               begin
                  d.fs[k] = live[k];
               end
               d.cap = CAP_IDLE;
            end
         end
      endcase
      d.pos = (q.cap == CAP_SAVE) ? live[servo_output_select_in]
                                  : q.fs[servo_output_select_in];
      for (int k = 0; k < NUM_OUT; k++)
      begin
         d.servo[k] = drive_en[k] && (q.frame_us < FRM_W'(live[k]));
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         q              <= '0;
         q.period_short <= PERIOD_RST;
         q.delay_sel    <= DELAY_RST_SEL;
         q.cap          <= CAP_IDLE;
         for (int k = 0; k < NUM_OUT; k++)
         begin
            q.pol[k]  <= POL_HOLD;
            q.src[k]  <= SRC_W'(k);
            q.fs[k]   <= FS_RST_US;
            q.hold[k] <= CENTER_US;
         end
      end
      else
      begin
         q <= d;
      end
   end

   assign capture_pending_out = (q.cap == CAP_SAVE);
   assign position_out        = q.pos;
   assign interference_out    = q.interf;
   assign servo_out           = q.servo;

   property p_frame_wrap;
      @(posedge core_clk_in) disable iff (rst_in)
      (tick && q.frame_us >= period_us - FRM_W'(1)) |=> (q.frame_us == '0);
   endproperty
   a_frame_wrap: assert property (p_frame_wrap) else $error("frame did not wrap");

   property p_src_follow;
      @(posedge core_clk_in) disable iff (rst_in)
      frame_valid_in |=> (q.hold[0] == $past(ch_width_in[q.src[0]]));
   endproperty
   a_src_follow: assert property (p_src_follow) else $error("output 0 not on source");

   property p_reset_hold;
      @(posedge core_clk_in) rst_in |=> (q.pol[0] == POL_HOLD && q.pol[NUM_OUT-1] == POL_HOLD);
   endproperty
   a_reset_hold: assert property (p_reset_hold) else $error("policy not hold after reset");

   property p_fs_drive;
      @(posedge core_clk_in) disable iff (rst_in)
      (q.seen && q.interf && fs_elapsed && q.pol[q.src[0]] == POL_FS) |-> (live[0] == q.fs[q.src[0]]);
   endproperty
   a_fs_drive: assert property (p_fs_drive) else $error("fail-safe width not driven");

   property p_hold;
      @(posedge core_clk_in) disable iff (rst_in)
      (q.seen && q.pol[q.src[0]] == POL_HOLD) |-> (live[0] == q.hold[0] && drive_en[0]);
   endproperty
   a_hold: assert property (p_hold) else $error("hold width lost");

   property p_off;
      @(posedge core_clk_in) disable iff (rst_in)
      (q.seen && q.interf && q.pol[q.src[0]] == POL_OFF) |=> !q.servo[0];
   endproperty
   a_off: assert property (p_off) else $error("off output still pulsing");

   property p_fs_range;
      @(posedge core_clk_in) disable iff (rst_in)
      // a capture commit in the same cycle overrides the written width
      (cfg_wr_in && !(q.cap == CAP_SAVE && capture_commit_in))
         |=> (q.fs[$past(servo_output_select_in)] >= FS_MIN_US
                     && q.fs[$past(servo_output_select_in)] <= FS_MAX_US);
   endproperty
   a_fs_range: assert property (p_fs_range) else $error("fail-safe width out of range");

   property p_delay_rst;
      @(posedge core_clk_in) rst_in |=> (q.delay_sel == DELAY_RST_SEL && q.fs[0] == FS_RST_US);
   endproperty
   a_delay_rst: assert property (p_delay_rst) else $error("delay or fs reset wrong");

   property p_boot;
      @(posedge core_clk_in) disable iff (rst_in)
      !q.seen |-> (live[0] == q.fs[q.src[0]] && drive_en[0]);
   endproperty
   a_boot: assert property (p_boot) else $error("boot width not fail-safe");

   property p_capture;
      @(posedge core_clk_in) disable iff (rst_in)
      (q.cap == CAP_SAVE && capture_commit_in) |=> (q.fs[0] == $past(live[0]) && q.cap == CAP_IDLE);
   endproperty
   a_capture: assert property (p_capture) else $error("capture not stored");

   property p_readout;
      @(posedge core_clk_in) disable iff (rst_in)
      (q.cap == CAP_SAVE) |=> (position_out == $past(live[servo_output_select_in]));
   endproperty
   a_readout: assert property (p_readout) else $error("readout not live");

   property p_center;
      @(posedge core_clk_in) rst_in |=> (q.hold[0] == CENTER_US);
   endproperty
   a_center: assert property (p_center) else $error("hold not centred");

   property p_interf;
      @(posedge core_clk_in) disable iff (rst_in)
      (q.lost_us >= period_us && !frame_valid_in) |=> interference_out;
   endproperty
   a_interf: assert property (p_interf) else $error("interference not declared");

   property p_interf_clr;
      @(posedge core_clk_in) disable iff (rst_in)
      frame_valid_in |=> !interference_out;
   endproperty
   a_interf_clr: assert property (p_interf_clr) else $error("interference not cleared");

endmodule : servo_failsafe_output
`default_nettype wire

// ### tb/radio_link_model.sv
// radio_link_model: transmitter side, sends decoded frames with widths base + index.
// assumes one clock; frames are sent only while run_in is high.
`timescale 1ns/1ns
`default_nettype none
module radio_link_model
   import servo_failsafe_pkg::*;
#(
   parameter int GAP = 1500
)
(
   // clock and control
   input  wire logic                     clk_in,
   input  wire logic                     run_in,
   input  wire logic [WID_W-1:0]         base_in,
   // decoded frame
   output logic                          frame_valid_out,
   output logic [NUM_OUT-1:0][WID_W-1:0] ch_width_out
);
   int cnt = 0;
   initial frame_valid_out = 1'b0;
   initial ch_width_out = '0;
   // sampled on the edge, driven by nba: no race with the bench's run_in
   always @(posedge clk_in)
   begin
      if (run_in && cnt == GAP - 1)
      begin
         cnt <= 0;
         frame_valid_out <= 1'b1;
         for (int i = 0; i < NUM_OUT; i++)
            ch_width_out[i] <= base_in + WID_W'(i);
      end
      else
      begin
         cnt <= run_in ? cnt + 1 : 0;
         frame_valid_out <= 1'b0;
         if (!run_in)
            ch_width_out <= ~ch_width_out;  // link down: never leave a stale width
      end
   end
endmodule : radio_link_model
`default_nettype wire

// ### tb/servo_failsafe_output_test.sv
// servo_failsafe_output_test: drives settings and link, checks sockets and readout.
// assumes shortened frame and delay parameters; 1 us is 100 clock cycles.
`timescale 1ns/1ns
`default_nettype none
module servo_failsafe_output_test;
   import servo_failsafe_pkg::*;
   localparam logic [WID_W-1:0] FULL = 11'h028;
   logic clk, rst, run, glob_wr, per_short, cfg_wr, cap_arm, cap_commit, fv, pend, intf;
   logic [1:0] dsel, pol;
   logic [SRC_W-1:0] osel, ssel;
   logic [STEP_W-1:0] step;
   logic [WID_W-1:0] base, pos;
   logic [NUM_OUT-1:0][WID_W-1:0] chw;
   logic [NUM_OUT-1:0] servo;
   logic [WID_W-1:0] w[NUM_OUT];
   int bad_count = 0;
   int tests_run = 0;
   int cyc = 0;
   radio_link_model #(.GAP(1500)) radio_link_model_inst (.clk_in(clk), .run_in(run),
      .base_in(base), .frame_valid_out(fv), .ch_width_out(chw));
   servo_failsafe_output #(.FRAME_SHORT_US(20), .FRAME_LONG_US(40), .DELAY_STEP_US(10))
      servo_failsafe_output_inst (.core_clk_in(clk), .rst_in(rst), .frame_valid_in(fv),
      .ch_width_in(chw), .glob_wr_in(glob_wr), .period_short_in(per_short),
      .delay_sel_in(dsel), .cfg_wr_in(cfg_wr), .servo_output_select_in(osel),
      .source_channel_select_in(ssel), .policy_in(pol), .fs_step_in(step),
      .capture_arm_in(cap_arm), .capture_commit_in(cap_commit),
      .capture_pending_out(pend), .position_out(pos), .interference_out(intf),
      .servo_out(servo));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic wrap_up;
      if (bad_count == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : wrap_up
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 80000)
      begin
         bad_count++;
         wrap_up;
      end
   end
   task automatic chk_val(input logic [WID_W-1:0] e, input logic [WID_W-1:0] g);
      tests_run++;
      if (g !== e)
      begin
         bad_count++;
         $display("unexpected width at %0t: exp %h got %h", $time, e, g);
      end
   endtask : chk_val
   task automatic chk_bit(input logic e, input logic g);
      tests_run++;
      if (g !== e)
      begin
         bad_count++;
         $display("unexpected flag at %0t: exp %h got %h", $time, e, g);
      end
   endtask : chk_bit
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic cfg(input logic [3:0] o, s, input logic [1:0] p, input logic [6:0] st);
      osel = o;
      ssel = s;
      pol = p;
      step = st;
      cfg_wr = 1'b1;
      tick(1);
      cfg_wr = 1'b0;
      tick(1);
   endtask : cfg
   task automatic glob(input logic ps);
      per_short = ps;
      glob_wr = 1'b1;
      tick(1);
      glob_wr = 1'b0;
      tick(1);
   endtask : glob
   // one long frame window; socket width in us read from its duty
   task automatic measure;
      int c[NUM_OUT];
      c = '{default: 0};
      repeat (4000)
      begin
         @(posedge clk);
         for (int k = 0; k < NUM_OUT; k++)
            c[k] += (servo[k] === 1'b1);
      end
      #1;
      for (int k = 0; k < NUM_OUT; k++)
         w[k] = WID_W'((c[k] + 50) / 100);
   endtask : measure
   task automatic expect_w(input logic [WID_W-1:0] e0, e1, e2, e3, e4);
      chk_val(e0, w[0]);
      chk_val(e1, w[1]);
      chk_val(e2, w[2]);
      chk_val(e3, w[3]);
      chk_val(e4, w[4]);
   endtask : expect_w
   task automatic wait_intf(input logic v, input int n);
      for (int i = 0; i < n && intf !== v; i++)
         tick(1);
      chk_bit(v, intf);
   endtask : wait_intf
   initial
   begin
      {rst, run, glob_wr, per_short, cfg_wr, cap_arm, cap_commit} = 7'h40;
      {pol, osel, ssel, step} = '0;
      dsel = DELAY_RST_SEL;
      base = 11'h005;
      tick(8);
      rst = 1'b0;
      tick(2);
      chk_bit(1'b0, pend);
      chk_val(CENTER_US, pos);
      measure;
      for (int k = 0; k < NUM_OUT; k++)
         chk_val(FULL, w[k]);
      glob(1'b0);
      cfg(4'h0, 4'h0, POL_HOLD, 7'h00);
      cfg(4'h1, 4'h1, POL_FS, 7'h7f);
      tick(1);
      chk_val(FS_MAX_US, pos);
      cfg(4'h2, 4'h2, POL_OFF, 7'h00);
      tick(1);
      chk_val(FS_MIN_US, pos);
      cfg(4'h3, 4'h1, POL_HOLD, 7'h00);  // own policy must be overruled by source slot
      run = 1'b1;
      tick(2000);
      measure;
      chk_bit(1'b0, intf);
      expect_w(11'h005, 11'h006, 11'h007, 11'h006, 11'h009);
      run = 1'b0;
      tick(2400);
      chk_bit(1'b0, intf);
      wait_intf(1'b1, 2000);
      tick(3200);
      measure;
      expect_w(11'h005, FULL, 11'h000, FULL, 11'h009);
      base = 11'h008;
      run = 1'b1;
      wait_intf(1'b0, 1600);
      tick(100);
      measure;
      expect_w(11'h008, 11'h009, 11'h00a, 11'h009, 11'h00c);
      dsel = 2'h3;
      glob(1'b1);
      measure;
      chk_val(11'h010, w[0]);
      chk_val(11'h012, w[1]);
      glob(1'b0);
      osel = 4'h1;
      cap_arm = 1'b1;
      tick(1);
      cap_arm = 1'b0;
      tick(2);
      chk_bit(1'b1, pend);
      chk_val(11'h009, pos);
      cap_commit = 1'b1;
      tick(1);
      cap_commit = 1'b0;
      tick(2);
      chk_bit(1'b0, pend);
      chk_val(11'h009, pos);
      // new live widths so that captured and held widths differ
      base = 11'h010;
      tick(1600);
      run = 1'b0;
      wait_intf(1'b1, 6000);
      tick(4200);
      measure;
      expect_w(11'h010, 11'h009, 11'h000, 11'h009, 11'h014);
      wrap_up;
   end
endmodule : servo_failsafe_output_test
`default_nettype wire
